// *** core/can_message_object_store.sv ***
/*
 Message-object store of a classic CAN controller: staging registers,
 message RAM, acceptance filtering of received frames and per-object flags.
 Assumes a protocol engine that presents received frames with valid/ready
 and reports finished transmissions as one-cycle pulses with object index.
*/
// The strobed register port and the address map were left to the implementer.
// How it works
// - Every object holds a 29-bit identifier, extended and direction flags, a 4-bit length code and eight bytes.
// - Only objects whose valid flag is set take part in reception and remote replies.
// - Direction 1 makes an object a transmit mailbox, direction 0 a receive mailbox.
// - A 29-bit mask per object picks the identifier bits that are compared.
// - The mask extended bit decides whether the frame's extended flag is compared.
// - The mask sense bit decides whether the direction flag is compared.
// - With use-mask clear the mask bits are ignored and every bit is compared.
// - The last-of-block bit ends a chain; full chain members are skipped, the last one is overwritten.
// - A finished transmission raises the object's pending flag when its transmit enable is set.
// - A stored frame raises the object's pending flag when its receive enable is set.
// - The pending flag stays set until software clears it, and a new event beats a clear.
// - Storing a frame sets the object's fresh-data flag.
module can_message_object_store #(
   parameter int OBJ_COUNT = 8,                          // Number of message objects
   parameter int IDX_W     = 3                           // Object index width
) (
   input  wire logic                  ref_clk,           // Module clock
   input  wire logic                  rst_n,             // Asynchronous reset, active low
   input  wire logic [7:0]            regAddr,           // Register byte address
   input  wire logic [31:0]           regWrData,         // Register write data
   input  wire logic                  regWrite,          // Write strobe
   input  wire logic                  regRead,           // Read strobe
   output logic      [31:0]           regRdData,         // Read data, cycle after strobe
   input  wire logic                  rxValid,           // Received frame offered
   output logic                       rxReady,           // Frame buffer has room
   input  wire logic [28:0]           rxId,              // Received identifier
   input  wire logic                  rxXtd,             // Received extended flag
   input  wire logic                  rxDir,             // Received remote-frame flag
   input  wire logic [3:0]            rxDlc,             // Received length code
   input  wire logic [63:0]           rxData,            // Received bytes, byte 0 low
   input  wire logic                  txDoneValid,       // Transmission finished pulse
   input  wire logic [IDX_W-1:0]      txDoneIdx,         // Object that was sent
   output logic [OBJ_COUNT-1:0]       sendPending,       // Send request per object
   output logic                       irqOut             // Any object pending
);

   typedef enum logic {XFER_IDLE, XFER_RUN} xfer_state_t;

   localparam int ID_W   = msg_store_pkg::ID_W;
   localparam int CTRL_W = msg_store_pkg::CTRL_W;
   localparam int FW     = msg_store_pkg::FRAME_W;
   localparam logic [1:0] CNT_W = 2'h2;
   localparam logic [IDX_W-1:0] LAST_CNT = IDX_W'(msg_store_pkg::TRANSFER_CYCLES - 1);

   // Message RAM
   logic [31:0]       maskMem [OBJ_COUNT];
   logic [31:0]       arbMem  [OBJ_COUNT];
   logic [CTRL_W-1:0] ctrlMem [OBJ_COUNT];
   logic [63:0]       dataMem [OBJ_COUNT];

   // Staging registers
   logic [31:0]       mask_reg;
   logic [31:0]       arb_reg;
   logic [CTRL_W-1:0] ctrl_reg;
   logic [63:0]       data_reg;
   logic [15:0]       cmd_reg;
   xfer_state_t       state_reg;
   logic [IDX_W-1:0]  cnt_reg;

   // Two-entry frame buffer
   logic [FW-1:0]     buf_reg [2];
   logic              wrPtr_reg;
   logic              rdPtr_reg;
   logic [1:0]        fill_reg;
   logic              rxReady_reg;
   logic [31:0]       rdData_reg;
   logic              irq_reg;
   logic [OBJ_COUNT-1:0] send_reg;

   function automatic logic accepts(input logic [31:0] msk, input logic [31:0] arb,
                                    input logic useMask, input logic [ID_W-1:0] id,
                                    input logic xtd, input logic dir);
      logic [ID_W-1:0] sel;
      logic            useExt;
      logic            useDir;
      sel    = useMask ? msk[ID_W-1:0] : {ID_W{1'b1}};
      useExt = !useMask || msk[msg_store_pkg::MSK_EXT];
      useDir = !useMask || msk[msg_store_pkg::MSK_SENSE];
      accepts = (((arb[ID_W-1:0] ^ id) & sel) == '0)
                && (!useExt || (arb[msg_store_pkg::ARB_XTD] == xtd))
                && (!useDir || (arb[msg_store_pkg::ARB_DIR] == dir));
   endfunction : accepts

   wire logic          bufValid  = (fill_reg != 2'h0);
   wire logic          push      = rxValid && rxReady_reg;
   wire logic          commitNow = (state_reg == XFER_RUN) && (cnt_reg == '0);
   wire logic          take      = bufValid && !commitNow;  // Stall avoids RAM port clash
   wire logic [FW-1:0] head      = buf_reg[rdPtr_reg];
   wire logic [ID_W-1:0] hId     = head[FW-1 -: ID_W];
   wire logic          hXtd      = head[FW-ID_W-1];
   wire logic          hDir      = head[FW-ID_W-2];
   wire logic [3:0]    hDlc      = head[67:64];
   wire logic [63:0]   hData     = head[63:0];
   wire logic [1:0]    fillNext  = fill_reg + {1'b0, push} - {1'b0, take};
   wire logic [IDX_W-1:0] cmdObj = cmd_reg[IDX_W-1:0];
   wire logic          cmdHit    = regWrite && (regAddr == msg_store_pkg::OFS_COMMAND);

   // First receive object, and every remote-reply object, that takes the head frame
   logic [OBJ_COUNT-1:0] rxCand;
   logic [OBJ_COUNT-1:0] rmtCand;
   logic [OBJ_COUNT-1:0] pendVec;
   genvar g;
   generate
      for (g = 0; g < OBJ_COUNT; g++)
      begin : g_obj
         wire logic ok = arbMem[g][msg_store_pkg::ARB_VALID]
                         && accepts(maskMem[g], arbMem[g], ctrlMem[g][msg_store_pkg::CTL_USE_ACCEPT_MASK],
                                    hId, hXtd, hDir);
         // Full chain members pass the frame on, the last one always takes it
         assign rxCand[g]  = ok && !arbMem[g][msg_store_pkg::ARB_DIR]
                             && (!ctrlMem[g][msg_store_pkg::CTL_FRESH]
                                 || ctrlMem[g][msg_store_pkg::CTL_LAST]);
         assign rmtCand[g] = ok && arbMem[g][msg_store_pkg::ARB_DIR] && hDir
                             && ctrlMem[g][msg_store_pkg::CTL_RMT];
         assign pendVec[g] = ctrlMem[g][msg_store_pkg::CTL_IRQ];
         assign send_reg[g] = ctrlMem[g][msg_store_pkg::CTL_SEND];
      end
   endgenerate

   logic [IDX_W-1:0] rxObj;
   logic             rxHit;
   always_comb
   begin
      rxObj = '0;
      rxHit = 1'b0;
      for (int i = OBJ_COUNT - 1; i >= 0; i--)
      begin
         if (rxCand[i])
         begin
            rxObj = IDX_W'(i);
            rxHit = 1'b1;
         end
      end
   end

   // Register read mux
   wire logic [31:0] rdMux =
      (regAddr == msg_store_pkg::OFS_COMMAND) ? ({16'h0000, cmd_reg[15:0] & 16'h7FFF}
                                                 | {16'h0000, state_reg == XFER_RUN, 15'h0000}) :
      (regAddr == msg_store_pkg::OFS_MASK)    ? mask_reg :
      (regAddr == msg_store_pkg::OFS_ARB)     ? arb_reg :
      (regAddr == msg_store_pkg::OFS_CTRL)    ? {16'h0000, ctrl_reg} :
      (regAddr == msg_store_pkg::OFS_DATA_LO) ? data_reg[31:0] :
      (regAddr == msg_store_pkg::OFS_DATA_HI) ? data_reg[63:32] :
      (regAddr == msg_store_pkg::OFS_PENDING) ? 32'(pendVec) : 32'h0000_0000;

   // Bus port, staging registers and transfer sequencer
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdData_reg <= 32'h0000_0000;
         mask_reg   <= msg_store_pkg::WORD_RESET;
         arb_reg    <= msg_store_pkg::WORD_RESET;
         ctrl_reg   <= 16'h0000;
         data_reg   <= 64'h0000_0000_0000_0000;
         cmd_reg    <= 16'h0000;
         state_reg  <= XFER_IDLE;
         cnt_reg    <= '0;
      end
      else
      begin
         rdData_reg <= regRead ? rdMux : 32'h0000_0000;
         if (regWrite && regAddr == msg_store_pkg::OFS_MASK)
            mask_reg <= regWrData;
         if (regWrite && regAddr == msg_store_pkg::OFS_ARB)
            arb_reg <= regWrData;
         if (regWrite && regAddr == msg_store_pkg::OFS_CTRL)
            ctrl_reg <= regWrData[CTRL_W-1:0];
         if (regWrite && regAddr == msg_store_pkg::OFS_DATA_LO)
            data_reg[31:0] <= regWrData;
         if (regWrite && regAddr == msg_store_pkg::OFS_DATA_HI)
            data_reg[63:32] <= regWrData;
         case (state_reg)
            XFER_IDLE:
            begin
               if (cmdHit)
               begin
                  cmd_reg   <= regWrData[15:0];
                  cnt_reg   <= LAST_CNT;
                  state_reg <= XFER_RUN;
               end
            end
            XFER_RUN:
            begin
               // Commands during a transfer are dropped; software polls busy
               if (cnt_reg != '0)
                  cnt_reg <= cnt_reg - 1'b1;
               else
               begin
                  state_reg <= XFER_IDLE;
                  if (!cmd_reg[msg_store_pkg::CMD_WRITE])
                  begin
                     if (cmd_reg[msg_store_pkg::CMD_ACC_MASK])
                        mask_reg <= maskMem[cmdObj];
                     if (cmd_reg[msg_store_pkg::CMD_ACC_ARB])
                        arb_reg <= arbMem[cmdObj];
                     if (cmd_reg[msg_store_pkg::CMD_ACC_CTRL])
                        ctrl_reg <= ctrlMem[cmdObj];
                     if (cmd_reg[msg_store_pkg::CMD_ACC_DATA])
                        data_reg <= dataMem[cmdObj];
                  end
               end
            end
            default:
               state_reg <= XFER_IDLE;
         endcase
      end
   end

   // Message RAM: commit first, then hardware events on top so an event beats a commit
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < OBJ_COUNT; i++)
         begin
            maskMem[i] <= msg_store_pkg::WORD_RESET;
            arbMem[i]  <= msg_store_pkg::WORD_RESET;
            ctrlMem[i] <= 16'h0000;
            dataMem[i] <= 64'h0000_0000_0000_0000;
         end
      end
      else
      begin
         if (commitNow && cmd_reg[msg_store_pkg::CMD_WRITE])
         begin
            if (cmd_reg[msg_store_pkg::CMD_ACC_MASK])
               maskMem[cmdObj] <= mask_reg;
            if (cmd_reg[msg_store_pkg::CMD_ACC_ARB])
               arbMem[cmdObj] <= arb_reg;
            if (cmd_reg[msg_store_pkg::CMD_ACC_CTRL])
               ctrlMem[cmdObj] <= ctrl_reg;
            if (cmd_reg[msg_store_pkg::CMD_ACC_DATA])
               dataMem[cmdObj] <= data_reg;
         end
         if (commitNow && cmd_reg[msg_store_pkg::CMD_CLR_IRQ])
            ctrlMem[cmdObj][msg_store_pkg::CTL_IRQ] <= 1'b0;
         if (commitNow && cmd_reg[msg_store_pkg::CMD_CLR_FRESH])
            ctrlMem[cmdObj][msg_store_pkg::CTL_FRESH] <= 1'b0;
         if (take && rxHit && !hDir)
         begin
            arbMem[rxObj][ID_W-1:0]               <= hId;
            arbMem[rxObj][msg_store_pkg::ARB_XTD] <= hXtd;
            dataMem[rxObj]                        <= hData;
            ctrlMem[rxObj][3:0]                   <= hDlc;
            ctrlMem[rxObj][msg_store_pkg::CTL_FRESH] <= 1'b1;
            ctrlMem[rxObj][msg_store_pkg::CTL_LOST] <= ctrlMem[rxObj][msg_store_pkg::CTL_FRESH];
            if (ctrlMem[rxObj][msg_store_pkg::CTL_RX_DONE_IRQ_EN])
               ctrlMem[rxObj][msg_store_pkg::CTL_IRQ] <= 1'b1;
         end
         for (int i = 0; i < OBJ_COUNT; i++)
         begin
            if (take && rmtCand[i])
               ctrlMem[i][msg_store_pkg::CTL_SEND] <= 1'b1;
         end
         if (txDoneValid)
         begin
            ctrlMem[txDoneIdx][msg_store_pkg::CTL_SEND] <= 1'b0;
            if (ctrlMem[txDoneIdx][msg_store_pkg::CTL_TX_DONE_IRQ_EN])
               ctrlMem[txDoneIdx][msg_store_pkg::CTL_IRQ] <= 1'b1;
         end
      end
   end

   // Frame buffer; draining stalls during a commit so a full buffer pushes back
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         buf_reg[0]  <= '0;
         buf_reg[1]  <= '0;
         wrPtr_reg   <= 1'b0;
         rdPtr_reg   <= 1'b0;
         fill_reg    <= 2'h0;
         rxReady_reg <= 1'b0;
         irq_reg     <= 1'b0;
         sendPending <= '0;
      end
      else
      begin
         if (push)
         begin
            buf_reg[wrPtr_reg] <= {rxId, rxXtd, rxDir, rxDlc, rxData};
            wrPtr_reg          <= !wrPtr_reg;
         end
         if (take)
            rdPtr_reg <= !rdPtr_reg;
         fill_reg    <= fillNext;
         rxReady_reg <= (fillNext < CNT_W);
         irq_reg     <= |pendVec;
         sendPending <= send_reg;
      end
   end

   assign regRdData = rdData_reg;
   assign rxReady   = rxReady_reg;
   assign irqOut    = irq_reg;

endmodule : can_message_object_store

// *** common/msg_store_pkg.sv ***
/*
 Shared constants of the message-object store: register offsets, field
 positions inside the staged words, and transfer timing.
 Assumes byte addresses on an 8-bit register port with 32-bit data.
*/
package msg_store_pkg;

   // Register offsets
   localparam logic [7:0] OFS_COMMAND = 8'h00;
   localparam logic [7:0] OFS_MASK    = 8'h04;
   localparam logic [7:0] OFS_ARB     = 8'h08;
   localparam logic [7:0] OFS_CTRL    = 8'h0C;
   localparam logic [7:0] OFS_DATA_LO = 8'h10;
   localparam logic [7:0] OFS_DATA_HI = 8'h14;
   localparam logic [7:0] OFS_PENDING = 8'h18;

   // Command word
   localparam int CMD_OBJ_W     = 8;
   localparam int CMD_WRITE     = 8;
   localparam int CMD_ACC_MASK  = 9;
   localparam int CMD_ACC_ARB   = 10;
   localparam int CMD_ACC_CTRL  = 11;
   localparam int CMD_ACC_DATA  = 12;
   localparam int CMD_CLR_IRQ   = 13;
   localparam int CMD_CLR_FRESH = 14;
   localparam int CMD_BUSY      = 15;

   // Mask word: identifier mask in [28:0]
   localparam int ID_W          = 29;
   localparam int MSK_SENSE     = 29;
   localparam int MSK_EXT       = 30;

   // Arbitration word: identifier in [28:0]
   localparam int ARB_DIR       = 29;
   localparam int ARB_XTD       = 30;
   localparam int ARB_VALID     = 31;

   // Control word: length code in [3:0]
   localparam int CTRL_W        = 16;
   localparam int DLC_W         = 4;
   localparam int CTL_LAST      = 7;
   localparam int CTL_SEND      = 8;
   localparam int CTL_RMT       = 9;
   localparam int CTL_RX_DONE_IRQ_EN      = 10;
   localparam int CTL_TX_DONE_IRQ_EN      = 11;
   localparam int CTL_USE_ACCEPT_MASK     = 12;
   localparam int CTL_IRQ       = 13;
   localparam int CTL_LOST      = 14;
   localparam int CTL_FRESH     = 15;

   // Frame and reset values
   localparam int PAYLOAD_BYTES = 8;
   localparam int FRAME_W       = ID_W + 2 + DLC_W + 8 * PAYLOAD_BYTES;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;

   // Transfer between staging registers and message RAM
   localparam real TRANSFER_NS     = 30.0;
   localparam real CLK_PERIOD_NS   = 10.0;
   localparam int  TRANSFER_CYCLES = int'($ceil(TRANSFER_NS / CLK_PERIOD_NS));

endpackage : msg_store_pkg

// *** tb/msg_store_chk.sv ***
/* Port checker of the message-object store, bound to every instance.
   Assumes the register and frame timing of the store's ports. */
module msg_store_chk #(
   parameter int OBJ_COUNT = 8,            // Objects
   parameter int IDX_W     = 3             // Index width
) (
   input wire logic                 ref_clk,     // Clock
   input wire logic                 rst_n,       // Reset, active low
   input wire logic [7:0]           regAddr,     // Address
   input wire logic                 regWrite,    // Write strobe
   input wire logic                 regRead,     // Read strobe
   input wire logic [31:0]          regRdData,   // Read data
   input wire logic                 rxValid,     // Frame offered
   input wire logic                 rxReady,     // Room in buffer
   input wire logic                 txDoneValid, // Sent pulse
   input wire logic [IDX_W-1:0]     txDoneIdx,   // Sent object
   input wire logic [OBJ_COUNT-1:0] sendPending, // Send requests
   input wire logic                 irqOut       // Any pending
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]       busyCnt_reg;
   logic [3:0]       sinceEv_reg;
   logic [3:0]       sinceCmd_reg;
   logic [IDX_W-1:0] doneIdx_reg;
   wire              busyNow = busyCnt_reg != 4'h0;
   // A command written while busy is dropped, so it starts no transfer
   wire              cmdTake = regWrite && regAddr == msg_store_pkg::OFS_COMMAND && !busyNow;
   wire              rxEv    = txDoneValid || (rxValid && rxReady);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busyCnt_reg  <= 4'h0;
         sinceEv_reg  <= 4'hF;
         sinceCmd_reg <= 4'hF;
         doneIdx_reg  <= '0;
      end
      else
      begin
         busyCnt_reg  <= cmdTake ? 4'(msg_store_pkg::TRANSFER_CYCLES) : busyCnt_reg - 4'(busyNow);
         sinceEv_reg  <= rxEv ? 4'h0 : sinceEv_reg + 4'(sinceEv_reg != 4'hF);
         sinceCmd_reg <= cmdTake ? 4'h0 : sinceCmd_reg + 4'(sinceCmd_reg != 4'hF);
         doneIdx_reg  <= txDoneValid ? txDoneIdx : doneIdx_reg;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_rdIdle; !$past(regRead) |-> regRdData == 32'h0; endproperty
   a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
   property p_busy; regRead && regAddr == msg_store_pkg::OFS_COMMAND |=> regRdData[15] == $past(busyNow); endproperty
   a_busy: assert property (p_busy) else $error("busy flag wrong");
   property p_unmapped; regRead && regAddr > msg_store_pkg::OFS_PENDING |=> regRdData == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_pendHigh; regRead && regAddr == msg_store_pkg::OFS_PENDING |=> regRdData[31:8] == 24'h0; endproperty
   a_pendHigh: assert property (p_pendHigh) else $error("pending upper bits set");
   property p_irqRise; $rose(irqOut) |-> sinceEv_reg <= 4'h8; endproperty
   a_irqRise: assert property (p_irqRise) else $error("interrupt without event");
   property p_irqFall; $fell(irqOut) |-> sinceCmd_reg <= 4'h8; endproperty
   a_irqFall: assert property (p_irqFall) else $error("interrupt dropped without clear");
   property p_sendDone; txDoneValid |-> ##3 !sendPending[doneIdx_reg]; endproperty
   a_sendDone: assert property (p_sendDone) else $error("send request not cleared");
   property p_sendStable; !$stable(sendPending) |-> sinceEv_reg <= 4'h8 || sinceCmd_reg <= 4'h8; endproperty
   a_sendStable: assert property (p_sendStable) else $error("send request changed alone");
   property p_readyFall; $fell(rxReady) |-> $past(rxValid); endproperty
   a_readyFall: assert property (p_readyFall) else $error("ready fell without frame");
endmodule : msg_store_chk

bind can_message_object_store msg_store_chk #(.OBJ_COUNT(OBJ_COUNT), .IDX_W(IDX_W)) chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
   .regRdData(regRdData), .rxValid(rxValid), .rxReady(rxReady), .txDoneValid(txDoneValid),
   .txDoneIdx(txDoneIdx), .sendPending(sendPending), .irqOut(irqOut));

// *** tb/can_frame_source.sv ***
/* Frame source standing for the protocol engine and the far nodes.
   Assumes the store takes a frame at an edge with valid and ready high. */
module can_frame_source (
   input  wire logic   ref_clk,     // Clock
   input  wire logic   rxReady,     // Store has room
   output logic        rxValid,     // Frame offered
   output logic [28:0] rxId,        // Identifier
   output logic        rxXtd,       // Extended flag
   output logic        rxDir,       // Remote frame
   output logic [3:0]  rxDlc,       // Length code
   output logic [63:0] rxData,      // Payload
   output logic        txDoneValid, // Sent pulse
   output logic [2:0]  txDoneIdx    // Sent object
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      rxValid = 1'b0;
      {rxId, rxXtd, rxDir, rxDlc, rxData} = '0;
      txDoneValid = 1'b0;
      txDoneIdx = 3'h0;
   end

   task automatic send_frame(input logic [28:0] id, input logic xtd, input logic dir, input logic [3:0] dlc,
                             input logic [63:0] data, input int lag, output logic ok);
      int n;
      n = 0;
      repeat (lag) @(posedge ref_clk);
      @(posedge ref_clk);
      rxValid <= 1'b1;
      {rxId, rxXtd, rxDir, rxDlc, rxData} <= {id, xtd, dir, dlc, data};
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (rxReady !== 1'b1 && n < 64);
      ok = rxReady === 1'b1;
      rxValid <= 1'b0;
      // Released fields flip so a stale frame is never mistaken for a new one
      {rxId, rxXtd, rxDir, rxDlc, rxData} <= ~{id, xtd, dir, dlc, data};
   endtask : send_frame

   task automatic finish_tx(input logic [2:0] idx);
      @(posedge ref_clk);
      txDoneValid <= 1'b1;
      txDoneIdx <= idx;
      @(posedge ref_clk);
      txDoneValid <= 1'b0;
      txDoneIdx <= ~idx;
   endtask : finish_tx
endmodule : can_frame_source

// *** tb/can_message_object_store_test.sv ***
/* Self-checking bench of the message-object store.
   Assumes the store's register map and a frame source on its receive side. */
module can_message_object_store_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0;
   logic        rst_n, regWrite, regRead, rxValid, rxReady, rxXtd, rxDir, txDoneValid, irqOut, ok;
   logic [7:0]  regAddr, sendPending;
   logic [31:0] regWrData, regRdData;
   logic [28:0] rxId;
   logic [3:0]  rxDlc;
   logic [63:0] rxData;
   logic [2:0]  txDoneIdx;
   int          bad_count = 0;
   int          comparisons = 0;

   always #5 ref_clk = ~ref_clk;

   can_message_object_store DUT (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .rxValid(rxValid), .rxReady(rxReady),
      .rxId(rxId), .rxXtd(rxXtd), .rxDir(rxDir), .rxDlc(rxDlc), .rxData(rxData), .txDoneValid(txDoneValid),
      .txDoneIdx(txDoneIdx), .sendPending(sendPending), .irqOut(irqOut));
   can_frame_source frameSrc (.ref_clk(ref_clk), .rxReady(rxReady), .rxValid(rxValid), .rxId(rxId),
      .rxXtd(rxXtd), .rxDir(rxDir), .rxDlc(rxDlc), .rxData(rxData), .txDoneValid(txDoneValid),
      .txDoneIdx(txDoneIdx));

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask : reg_wr

   // Data stand only in the cycle after the strobe; taken at the edge closing it
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
      @(posedge ref_clk);
      d = regRdData;
   endtask : reg_rd

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      reg_rd(a, d);
      check(d, exp);
   endtask : rd_chk

   // Poll busy with a bound; the latched command must read back once idle
   task automatic wait_idle(input logic [31:0] cmd);
      logic [31:0] d;
      int          n;
      d = 32'h0000_8000;
      for (n = 0; n < 20 && d[15] !== 1'b0; n++)
         reg_rd(msg_store_pkg::OFS_COMMAND, d);
      if (d[15] !== 1'b0)
      begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, d, cmd & 32'h7FFF);
         wrap_up();
      end
      check(d, cmd & 32'h7FFF);
   endtask : wait_idle

   task automatic commit(input logic [31:0] cmd);
      reg_wr(msg_store_pkg::OFS_COMMAND, cmd);
      rd_chk(msg_store_pkg::OFS_COMMAND, cmd | 32'h8000);
      wait_idle(cmd);
   endtask : commit

   task automatic frame(input logic [28:0] id, input logic xtd, input logic dir, input logic [63:0] d, input int lag);
      frameSrc.send_frame(id, xtd, dir, 4'h8, d, lag, ok);
      check({31'h0, ok}, 32'h1);
   endtask : frame

   initial
   begin
      {rst_n, regWrite, regRead, regAddr, regWrData} = '0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int a = 0; a <= 8'h1C; a += 4)
         rd_chk(8'(a), msg_store_pkg::WORD_RESET);
      reg_wr(msg_store_pkg::OFS_MASK, 32'h7FFF_FFF0);
      reg_wr(msg_store_pkg::OFS_ARB, 32'hCABC_DE10);
      reg_wr(msg_store_pkg::OFS_CTRL, 32'h0000_1480);
      commit(32'h0000_1F01);
      reg_wr(msg_store_pkg::OFS_MASK, 32'h0000_0000);
      reg_wr(msg_store_pkg::OFS_ARB, 32'hA000_0123);
      reg_wr(msg_store_pkg::OFS_CTRL, 32'h0000_0B82);
      commit(32'h0000_1F02);
      check({24'h0, sendPending}, 32'h4);
      frame(29'h0ABC_DE1F, 1'b1, 1'b0, 64'h8877_6655_4433_2211, 0);
      frame(29'h0ABC_DF10, 1'b1, 1'b0, 64'hDEAD_0001_DEAD_0001, 0);
      frame(29'h0ABC_DE10, 1'b0, 1'b0, 64'hDEAD_0002_DEAD_0002, 0);
      frame(29'h0ABC_DE10, 1'b1, 1'b1, 64'hDEAD_0003_DEAD_0003, 0);
      frame(29'h0000_0000, 1'b0, 1'b0, 64'hDEAD_0004_DEAD_0004, 3);
      repeat (4) @(posedge ref_clk);
      check({31'h0, irqOut}, 32'h1);
      rd_chk(msg_store_pkg::OFS_PENDING, 32'h2);
      commit(32'h0000_1E01);
      rd_chk(msg_store_pkg::OFS_CTRL, 32'h0000_B488);
      rd_chk(msg_store_pkg::OFS_DATA_LO, 32'h4433_2211);
      rd_chk(msg_store_pkg::OFS_DATA_HI, 32'h8877_6655);
      commit(32'h0000_7E01);
      commit(32'h0000_1E01);
      rd_chk(msg_store_pkg::OFS_CTRL, 32'h0000_1488);
      rd_chk(msg_store_pkg::OFS_ARB, 32'hCABC_DE1F);
      rd_chk(msg_store_pkg::OFS_DATA_HI, 32'h8877_6655);
      rd_chk(msg_store_pkg::OFS_PENDING, 32'h0);
      check({31'h0, irqOut}, 32'h0);
      frameSrc.finish_tx(3'h2);
      repeat (4) @(posedge ref_clk);
      check({24'h0, sendPending}, 32'h0);
      check({31'h0, irqOut}, 32'h1);
      rd_chk(msg_store_pkg::OFS_PENDING, 32'h4);
      frameSrc.send_frame(29'h0000_0123, 1'b0, 1'b1, 4'h0, 64'h0, 0, ok);
      check({31'h0, ok}, 32'h1);
      repeat (4) @(posedge ref_clk);
      check({24'h0, sendPending}, 32'h4);
      reg_wr(msg_store_pkg::OFS_COMMAND, 32'h0000_1E02);
      reg_wr(msg_store_pkg::OFS_COMMAND, 32'h0000_1E01);
      wait_idle(32'h0000_1E02);
      rd_chk(msg_store_pkg::OFS_ARB, 32'hA000_0123);
      // Chain: object 0 not last, object 1 last; a full object 0 passes frames on
      reg_wr(msg_store_pkg::OFS_MASK, 32'h7FFF_FFF0);
      reg_wr(msg_store_pkg::OFS_ARB, 32'hCABC_DE10);
      reg_wr(msg_store_pkg::OFS_CTRL, 32'h0000_1400);
      commit(32'h0000_1F00);
      frame(29'h0ABC_DE11, 1'b1, 1'b0, 64'h0000_0000_5555_6666, 0);
      frame(29'h0ABC_DE12, 1'b1, 1'b0, 64'h0000_0000_1111_2222, 0);
      frame(29'h0ABC_DE13, 1'b1, 1'b0, 64'h0000_0000_3333_4444, 0);
      commit(32'h0000_1E01);
      rd_chk(msg_store_pkg::OFS_CTRL, 32'h0000_F488);
      rd_chk(msg_store_pkg::OFS_DATA_LO, 32'h3333_4444);
      commit(32'h0000_1E00);
      rd_chk(msg_store_pkg::OFS_ARB, 32'hCABC_DE11);
      rd_chk(msg_store_pkg::OFS_DATA_LO, 32'h5555_6666);
      wrap_up();
   end
endmodule : can_message_object_store_test
